// [hdl/dbm_pkg.sv]
// Purpose: shared constants for the dc brake and motor set select block
// Assumes: 200 MHz pclk, apb with 32-bit data
// Notes: delay in tenths of a second, force in percent
package dbm_pkg;
   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned DBM_CLK_HZ = 200_000_000;
   localparam int unsigned DBM_TENTH_NS = 100_000_000;
   localparam int unsigned DBM_CLK_NS = 5;
   localparam int unsigned DBM_TENTH_CYC = DBM_TENTH_NS / DBM_CLK_NS;
   localparam logic [6:0] DBM_DELAY_MIN = 7'h01;
   localparam logic [6:0] DBM_DELAY_MAX = 7'h32;
   localparam logic [6:0] DBM_DELAY_RST = 7'h05;
   localparam logic [6:0] DBM_FORCE_MAX = 7'h64;
   localparam logic [6:0] DBM_FORCE_RST = 7'h32;
   localparam logic [7:0] DBM_SET_OPT_CODE = 8'h08;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [11:0] DBM_A_CTRL = 12'h000;
   localparam logic [11:0] DBM_A_DELAY = 12'h004;
   localparam logic [11:0] DBM_A_FORCE = 12'h008;
   localparam logic [11:0] DBM_A_STAT = 12'h00c;
   localparam logic [11:0] DBM_A_FREQ = 12'h010;
   localparam int unsigned DBM_C_KEYPAD = 0;
   localparam int unsigned DBM_C_RUN = 1;
   localparam int unsigned DBM_C_DECEL = 2;
   localparam logic [15:0] DBM_FREQ_RST = 16'h0000;
   localparam logic [15:0] DBM_RAMP_STEP = 16'h0001;
   typedef enum logic [2:0] {
      DBM_IDLE, DBM_RUN, DBM_COAST, DBM_BRAKE, DBM_RAMP, DBM_HOLD_OFF
   } dbm_state_t;
endpackage

// [hdl/dbm_if.sv]
// Purpose: carries the brake timing handshake between top and timer
// Assumes: single pclk domain
// Notes: start is a level held while timing is wanted
interface dbm_tmr_if;
   logic start;
   logic [6:0] tenths;
   logic done;
   modport ctl (output start, output tenths, input done);
   modport tmr (input start, input tenths, output done);
endinterface

// [hdl/dbm_delay_tmr.sv]
// Purpose: counts the brake delay in tenths of a second
// Assumes: tenths stable while start is high
// Notes: done stays high until start drops
module dbm_delay_tmr
   import dbm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   dbm_tmr_if.tmr t
);
   logic [24:0] cyc_q;
   logic [6:0] ten_q;
   logic done_q;
   // ----------------------------------------------------------------
   // prescaler and tenth counter; restarts whenever start drops
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_q <= '0;
         ten_q <= '0;
         done_q <= 1'b0;
      end else if (!t.start) begin
         cyc_q <= '0;
         ten_q <= '0;
         done_q <= 1'b0;
      end else if (!done_q) begin
         if (cyc_q == 25'(DBM_TENTH_CYC - 1)) begin
            cyc_q <= '0;
            ten_q <= ten_q + 7'h01;
            if (ten_q + 7'h01 >= t.tenths) begin
               done_q <= 1'b1;
            end
         end else begin
            cyc_q <= cyc_q + 25'h0000001;
         end
      end
   end
   assign t.done = done_q;
endmodule

// [hdl/dbm_top.sv]
// Purpose: external dc brake request and motor parameter set select
// Assumes: terminal inputs synchronous to pclk, apb register access
// Notes: frequency model steps straight to the target setting in run and ramps back to the prior level after braking in terminal run
//
// Functional notes
// - brake request input asserted enables the dc braking function.
// - brake delay accepts 0.1 to 5.0 s, other writes rejected.
// - brake force setting kept within 0 to 100 percent.
// - terminal run: brake while requested, then ramp back to prior frequency.
// - keypad run: brake while requested, then output stays off.
// - keypad run: coast with output off until delay expires, then brake.
// - dc injection during deceleration only while brake request is on.
// - set select high uses secondary motor parameter set, option code 08.
// - set select low uses primary motor parameter set.
// - set select changes while running ignored until the drive stops.
module dbm_top
   import dbm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic forward_run_in,
   input wire logic reverse_run_in,
   input wire logic ext_brake_request,
   input wire logic motor_set_sel_in,
   output logic output_on,
   output logic dc_brake_on,
   output logic [6:0] dc_brake_force,
   output logic second_set_active,
   output logic [15:0] out_freq
);
   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   logic [2:0] ctrl_q;
   logic [6:0] delay_q;
   logic [6:0] force_q;
   logic [15:0] target_q;
   logic [15:0] freq_q;
   logic [15:0] prior_q;
   logic brk_q;
   logic sel_q;
   logic set2_q;
   logic rej_q;
   logic dc_q;
   logic on_q;
   dbm_state_t st_q;
   dbm_state_t st_d;
   logic run_cmd;
   logic keypad;
   logic wr;
   logic rd_ok;
   logic [31:0] rd_mux;
   logic [31:0] prdata_q;
   dbm_tmr_if tif ();

   dbm_delay_tmr u_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .t(tif.tmr)
   );

   assign keypad = ctrl_q[DBM_C_KEYPAD];
   assign run_cmd = keypad ? ctrl_q[DBM_C_RUN] : (forward_run_in | reverse_run_in);
   assign wr = psel & penable & pwrite;
   assign pready = 1'b1;

   // ----------------------------------------------------------------
   // input sampling as plain levels, one flop
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_q <= 1'b0;
         sel_q <= 1'b0;
      end else begin
         brk_q <= ext_brake_request;
         sel_q <= motor_set_sel_in;
      end
   end

   // ----------------------------------------------------------------
   // apb writes; out of range delay refused, force clipped
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         delay_q <= DBM_DELAY_RST;
         force_q <= DBM_FORCE_RST;
         target_q <= DBM_FREQ_RST;
         rej_q <= 1'b0;
      end else if (wr) begin
         unique case (paddr)
            DBM_A_CTRL: ctrl_q <= pwdata[2:0];
            DBM_A_DELAY: begin
               if (pwdata >= 32'(DBM_DELAY_MIN) && pwdata <= 32'(DBM_DELAY_MAX)) begin
                  delay_q <= pwdata[6:0];
                  rej_q <= 1'b0;
               end else begin
                  rej_q <= 1'b1;
               end
            end
            DBM_A_FORCE: begin
               // clip instead of refuse so a large value means full force
               force_q <= (pwdata > 32'(DBM_FORCE_MAX)) ? DBM_FORCE_MAX : pwdata[6:0];
            end
            DBM_A_FREQ: target_q <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // apb read mux; unmapped reads zero with pslverr
   // ----------------------------------------------------------------
   always_comb begin
      rd_mux = '0;
      rd_ok = 1'b1;
      unique case (paddr)
         DBM_A_CTRL: rd_mux = {29'h0, ctrl_q};
         DBM_A_DELAY: rd_mux = {25'h0, delay_q};
         DBM_A_FORCE: rd_mux = {25'h0, force_q};
         DBM_A_STAT: rd_mux = {16'h0, DBM_SET_OPT_CODE, 2'h0, rej_q, set2_q, dc_q, st_q};
         DBM_A_FREQ: rd_mux = {16'h0, freq_q};
         default: rd_ok = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~rd_ok;

   // read word captured at the end of setup so prdata leaves a flop;
   // costs no wait state since the access phase always follows setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
      end else if (psel & ~penable) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata = prdata_q;

   // ----------------------------------------------------------------
   // motor set selection latched only while stopped
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set2_q <= 1'b0;
      end else if (st_q == DBM_IDLE) begin
         set2_q <= sel_q;
      end
   end

   // ----------------------------------------------------------------
   // brake sequencing
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         DBM_IDLE: if (run_cmd) st_d = DBM_RUN;
         DBM_RUN: begin
            if (!run_cmd) st_d = DBM_IDLE;
            else if (brk_q) st_d = keypad ? DBM_COAST : DBM_BRAKE;
         end
         DBM_COAST: begin
            if (!brk_q) st_d = DBM_HOLD_OFF;
            else if (tif.done) st_d = DBM_BRAKE;
         end
         DBM_BRAKE: begin
            if (!brk_q) st_d = keypad ? DBM_HOLD_OFF : DBM_RAMP;
         end
         DBM_RAMP: begin
            if (!run_cmd) st_d = DBM_IDLE;
            else if (brk_q) st_d = DBM_BRAKE;
            else if (freq_q >= prior_q) st_d = DBM_RUN;
         end
         DBM_HOLD_OFF: if (!run_cmd) st_d = DBM_IDLE;
         default: st_d = DBM_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= DBM_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   assign tif.start = (st_q == DBM_COAST) & brk_q;
   assign tif.tenths = delay_q;

   // ----------------------------------------------------------------
   // frequency: remembers level before braking, ramps back after
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_q <= DBM_FREQ_RST;
         prior_q <= DBM_FREQ_RST;
      end else begin
         unique case (st_q)
            DBM_RUN: begin
               freq_q <= target_q;
               prior_q <= target_q;
            end
            DBM_RAMP: begin
               if (freq_q < prior_q) freq_q <= freq_q + DBM_RAMP_STEP;
            end
            default: freq_q <= DBM_FREQ_RST;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // outputs from flops; injection only while the request is on
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dc_q <= 1'b0;
         on_q <= 1'b0;
      end else begin
         dc_q <= (st_d == DBM_BRAKE) & brk_q;
         on_q <= (st_d == DBM_RUN) | (st_d == DBM_RAMP);
      end
   end

   assign dc_brake_on = dc_q;
   assign output_on = on_q;
   assign dc_brake_force = force_q;
   assign second_set_active = set2_q;
   assign out_freq = freq_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_brake_needs_req;
      @(posedge pclk) disable iff (!presetn) dc_brake_on |-> $past(brk_q);
   endproperty
   a_brake_needs_req: assert property (p_brake_needs_req) else $error("brake without request");

   property p_keypad_hold;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_HOLD_OFF && run_cmd) |=> !output_on;
   endproperty
   a_keypad_hold: assert property (p_keypad_hold) else $error("output resumed in keypad");

   property p_set_stable_run;
      @(posedge pclk) disable iff (!presetn)
         (st_q != DBM_IDLE) |=> $stable(set2_q);
   endproperty
   a_set_stable_run: assert property (p_set_stable_run) else $error("set changed while running");

   property p_set_follow;
      @(posedge pclk) disable iff (!presetn) (st_q == DBM_IDLE) |=> set2_q == $past(sel_q);
   endproperty
   a_set_follow: assert property (p_set_follow) else $error("set not taken when stopped");

   property p_delay_range;
      @(posedge pclk) disable iff (!presetn)
         delay_q >= DBM_DELAY_MIN && delay_q <= DBM_DELAY_MAX;
   endproperty
   a_delay_range: assert property (p_delay_range) else $error("delay out of range");

   property p_force_range;
      @(posedge pclk) disable iff (!presetn) force_q <= DBM_FORCE_MAX;
   endproperty
   a_force_range: assert property (p_force_range) else $error("force out of range");

   sequence s_coast;
      st_q == DBM_COAST && brk_q && !tif.done;
   endsequence
   property p_coast_off;
      @(posedge pclk) disable iff (!presetn) s_coast |=> !dc_brake_on && !output_on;
   endproperty
   a_coast_off: assert property (p_coast_off) else $error("output during coast");

   property p_term_brake;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_RUN && run_cmd && brk_q && !keypad) |=> dc_brake_on;
   endproperty
   a_term_brake: assert property (p_term_brake) else $error("terminal brake missing");

   property p_ramp_back;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_BRAKE && !brk_q && !keypad) |=> st_q == DBM_RAMP;
   endproperty
   a_ramp_back: assert property (p_ramp_back) else $error("no ramp after brake");

   property p_sample;
      @(posedge pclk) disable iff (!presetn) brk_q == $past(ext_brake_request);
   endproperty
   a_sample: assert property (p_sample) else $error("brake input not sampled");

   sequence s_kp_brake_req;
      st_q == DBM_RUN && run_cmd && brk_q && keypad;
   endsequence
   property p_kp_coast_first;
      @(posedge pclk) disable iff (!presetn)
         s_kp_brake_req |=> st_q == DBM_COAST && !dc_brake_on && !output_on;
   endproperty
   a_kp_coast_first: assert property (p_kp_coast_first) else $error("keypad did not coast");

   // expiry takes tenths of a second of clock, so only long runs reach it
   property p_delay_expired;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_COAST && brk_q && tif.done) |=> dc_brake_on;
   endproperty
   a_delay_expired: assert property (p_delay_expired) else $error("no brake after delay");

   property p_kp_no_resume;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_BRAKE && !brk_q && keypad) |=> st_q == DBM_HOLD_OFF && !output_on;
   endproperty
   a_kp_no_resume: assert property (p_kp_no_resume) else $error("keypad output resumed");

   property p_ramp_step;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_RAMP && freq_q < prior_q) |=> freq_q == $past(freq_q) + DBM_RAMP_STEP;
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp step wrong");

   property p_run_freq;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_RUN) |=> freq_q == $past(target_q) && prior_q == $past(target_q);
   endproperty
   a_run_freq: assert property (p_run_freq) else $error("run level not kept");

   property p_off_no_dc;
      @(posedge pclk) disable iff (!presetn) !brk_q |=> !dc_brake_on;
   endproperty
   a_off_no_dc: assert property (p_off_no_dc) else $error("injection without request");

   property p_delay_refused;
      @(posedge pclk) disable iff (!presetn)
         (wr && paddr == DBM_A_DELAY &&
          (pwdata < 32'(DBM_DELAY_MIN) || pwdata > 32'(DBM_DELAY_MAX)))
         |=> $stable(delay_q) && rej_q;
   endproperty
   a_delay_refused: assert property (p_delay_refused) else $error("bad delay taken");

   property p_force_clip;
      @(posedge pclk) disable iff (!presetn)
         (wr && paddr == DBM_A_FORCE && pwdata > 32'(DBM_FORCE_MAX))
         |=> force_q == DBM_FORCE_MAX;
   endproperty
   a_force_clip: assert property (p_force_clip) else $error("force not clipped");

   property p_term_resume;
      @(posedge pclk) disable iff (!presetn)
         (st_q == DBM_BRAKE && !brk_q && !keypad && run_cmd) |=> output_on;
   endproperty
   a_term_resume: assert property (p_term_resume) else $error("output not resumed");
endmodule

// [dv/dbm_sw_model.sv]
// Purpose: terminal switches that feed the run, brake and set select inputs
// Assumes: one pclk domain, levels change just after a rising edge
// Notes: the bench commands new levels through set_levels
module dbm_sw_model (
   input wire logic pclk,
   output logic forward_run_in,
   output logic reverse_run_in,
   output logic ext_brake_request,
   output logic motor_set_sel_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // switches rest open at power up
   initial begin
      forward_run_in = 1'b0;
      reverse_run_in = 1'b0;
      ext_brake_request = 1'b0;
      motor_set_sel_in = 1'b0;
   end
   // levels are held until the next command, never pulsed
   task automatic set_levels(input logic fw, input logic rv, input logic db, input logic sel);
      @(posedge pclk);
      forward_run_in <= fw;
      reverse_run_in <= rv;
      ext_brake_request <= db;
      motor_set_sel_in <= sel;
   endtask
endmodule

// [dv/tb.sv]
// Purpose: self-checking bench for the brake and motor set select block
// Assumes: apb answers with pready, terminals driven by the switch model
// Notes: the keypad brake delay is far too long to see expire here
module tb;
   import dbm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic forward_run_in, reverse_run_in, ext_brake_request, motor_set_sel_in;
   logic output_on, dc_brake_on, second_set_active;
   logic [6:0] dc_brake_force;
   logic [15:0] out_freq;
   int errors = 0;
   int n_checks = 0;
   logic [31:0] rd;
   logic er;
   // 200 MHz clock
   always #2.5 pclk = ~pclk;
   dbm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .forward_run_in(forward_run_in), .reverse_run_in(reverse_run_in),
      .ext_brake_request(ext_brake_request), .motor_set_sel_in(motor_set_sel_in),
      .output_on(output_on), .dc_brake_on(dc_brake_on), .dc_brake_force(dc_brake_force),
      .second_set_active(second_set_active), .out_freq(out_freq));
   dbm_sw_model sw (.pclk(pclk), .forward_run_in(forward_run_in),
      .reverse_run_in(reverse_run_in), .ext_brake_request(ext_brake_request),
      .motor_set_sel_in(motor_set_sel_in));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic close_out();
      if (errors == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer; pready and the answer are taken at the same rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         chk("pready", 32'h1, 32'h0);
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, exp, rd);
   endtask
   // polls the status word; terminal effects take a few edges to land
   task automatic wait_stat(input string nm, input logic [31:0] m, input logic [31:0] v);
      int k;
      for (k = 0; k < 60; k++) begin
         apb(1'b0, DBM_A_STAT, 32'h0);
         if ((rd & m) === v) break;
      end
      chk(nm, v, rd & m);
      if ((rd & m) !== v) close_out();
   endtask
   task automatic wait_freq(input logic [15:0] v);
      int k;
      for (k = 0; k < 80; k++) begin
         @(negedge pclk);
         if (out_freq === v) break;
      end
      chk("out_freq", {16'h0, v}, {16'h0, out_freq});
      if (out_freq !== v) close_out();
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   logic [31:0] dly_in [4] = '{32'h0, 32'h33, 32'h32, 32'h1};
   logic [31:0] dly_ex [4] = '{32'h5, 32'h5, 32'h32, 32'h1};
   logic [31:0] frc_in [4] = '{32'h65, 32'h64, 32'h0, 32'h3c};
   logic [31:0] frc_ex [4] = '{32'h64, 32'h64, 32'h0, 32'h3c};
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("delay_rst", DBM_A_DELAY, {25'h0, DBM_DELAY_RST});
      rdc("force_rst", DBM_A_FORCE, {25'h0, DBM_FORCE_RST});
      rdc("stat_rst", DBM_A_STAT, {16'h0, DBM_SET_OPT_CODE, 8'h00});
      chk("force_pin", {25'h0, DBM_FORCE_RST}, {25'h0, dc_brake_force});
      // out of range delays leave the old value; the first is flagged
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, DBM_A_DELAY, dly_in[i]);
         rdc("delay", DBM_A_DELAY, dly_ex[i]);
         if (i == 0) rdc("stat_rej", DBM_A_STAT, {16'h0, DBM_SET_OPT_CODE, 8'h20});
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, DBM_A_FORCE, frc_in[i]);
         rdc("force", DBM_A_FORCE, frc_ex[i]);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_rd", 32'h0, rd);
      // set select copied while stopped
      sw.set_levels(1'b0, 1'b0, 1'b0, 1'b1);
      wait_stat("set2_on", 32'h10, 32'h10);
      chk("set2_pin", 32'h1, {31'h0, second_set_active});
      sw.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
      wait_stat("set2_off", 32'h10, 32'h0);
      apb(1'b1, DBM_A_FREQ, 32'h8);
      // terminal run, forward then reverse
      for (int i = 0; i < 2; i++) begin
         sw.set_levels(i == 0, i == 1, 1'b0, 1'b0);
         wait_stat("run", 32'h1f, 32'h01);
         wait_freq(16'h0008);
         chk("no_dc_run", 32'h0, {31'h0, dc_brake_on});
         chk("out_on", 32'h1, {31'h0, output_on});
         sw.set_levels(i == 0, i == 1, 1'b1, 1'b1);
         wait_stat("brake", 32'h1f, 32'h0b);
         chk("dc_pin", 32'h1, {31'h0, dc_brake_on});
         chk("force_pin", 32'h3c, {25'h0, dc_brake_force});
         sw.set_levels(i == 0, i == 1, 1'b0, 1'b1);
         wait_stat("rerun", 32'h1f, 32'h01);
         wait_freq(16'h0008);
         chk("set_held", 32'h0, {31'h0, second_set_active});
         sw.set_levels(1'b0, 1'b0, 1'b0, 1'b1);
         wait_stat("stop_set2", 32'h17, 32'h10);
         sw.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
         wait_stat("stop_set1", 32'h17, 32'h00);
      end
      // keypad run: coast first, then no resume after release
      apb(1'b1, DBM_A_CTRL, 32'h3);
      wait_stat("kp_run", 32'h0f, 32'h01);
      sw.set_levels(1'b0, 1'b0, 1'b1, 1'b0);
      wait_stat("coast", 32'h0f, 32'h02);
      chk("coast_out", 32'h0, {30'h0, output_on, dc_brake_on});
      sw.set_levels(1'b0, 1'b0, 1'b0, 1'b0);
      wait_stat("hold_off", 32'h0f, 32'h05);
      chk("hold_out", 32'h0, {31'h0, output_on});
      apb(1'b1, DBM_A_CTRL, 32'h1);
      wait_stat("kp_idle", 32'h0f, 32'h00);
      close_out();
   end
endmodule
